//--- design/addr_stack_pkg.sv
package addr_stack_pkg;

  // ---------------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned STACK_IDX_W = 4;
  localparam int unsigned STACK_DEPTH = 1 << STACK_IDX_W;
  localparam logic [STACK_IDX_W-1:0] STACK_IDX_RESET = 4'h0F;
  localparam logic [WORD_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] ONE = 16'h0001;
  localparam int unsigned NUM_DP = 2;

  // Pointer access modes requested by the decoder.
  typedef enum logic [1:0] {
    STEP_NONE = 2'b00,
    STEP_INC = 2'b01,
    STEP_DEC = 2'b10
  } step_t;

  // Stack operations requested by the decoder.
  typedef enum logic [2:0] {
    STK_IDLE = 3'b000,
    STK_PUSH = 3'b001,
    STK_CALL = 3'b010,
    STK_VECTOR = 3'b011,
    STK_POP = 3'b100,
    STK_RET = 3'b101,
    STK_RETURN_FROM_INTERRUPT = 3'b110,
    STK_POPC = 3'b111
  } stk_op_t;

endpackage : addr_stack_pkg

//--- design/hw_stack.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------------
// Dedicated return stack with its own index
// ---------------------------------------------------------------------------
module hw_stack (
  input wire logic clock,
  input wire logic reset,
  input wire logic push,
  input wire logic pop,
  input wire logic [addr_stack_pkg::WORD_W-1:0] push_data,
  output logic [addr_stack_pkg::WORD_W-1:0] top_data,
  output logic [addr_stack_pkg::STACK_IDX_W-1:0] stack_index
);
  import addr_stack_pkg::*;

  // Storage has no reset, so contents are unknown until written.
  logic [WORD_W-1:0] mem [STACK_DEPTH];
  logic [STACK_IDX_W-1:0] stack_index_q;
  logic [STACK_IDX_W-1:0] next_index;

  // Push steps first, then writes; wrap is modulo depth with no error.
  assign next_index = stack_index_q + 4'h1;
  assign top_data = mem[stack_index_q];
  assign stack_index = stack_index_q;

  // Index register, reset to top of stack.
  always_ff @(posedge clock) begin
    if (reset) begin
      stack_index_q <= STACK_IDX_RESET;
    end else if (push) begin
      stack_index_q <= next_index;
    end else if (pop) begin
      stack_index_q <= stack_index_q - 4'h1;
    end
  end

  // Memory write is unreset on purpose; only stack ops reach it.
  always_ff @(posedge clock) begin
    if (push && !reset) begin
      mem[next_index] <= push_data;
    end
  end

  push_step_a: assert property (@(posedge clock) disable iff (reset)
    push |=> stack_index_q == $past(stack_index_q) + 4'h1)
    else $error("stack index did not rise on push");

  pop_step_a: assert property (@(posedge clock) disable iff (reset)
    pop && !push |=> stack_index_q == $past(stack_index_q) - 4'h1)
    else $error("stack index did not fall on pop");

endmodule : hw_stack

`default_nettype wire

//--- design/stack_and_pointer_addressing.sv
// Contract
// - Data pointer increment: after a read, or before a write.
// - Data pointer decrement: after a read, or before a write.
// - Frame address is unsigned 16-bit sum of base and offset.
// - Frame increment steps offset before write, after read.
// - Frame decrement steps offset before write, after read.
// - Only the offset steps; carry never reaches the frame base.
// - Each data memory access completes in one clock cycle.
// - Data accesses may be word or byte wide.
// - Stack entries are 16 bits wide.
// - Stack serves call, return, interrupts, push, pop and moves.
// - Pop-and-clear pops normally and also clears the in-service flag; the code keeps the flag set when set_in_service comes in the same cycle.
// - Stack depth is two to the index width.
// - Reset loads the stack index with top of stack.
// - Push-type operations increment index then write.
// - Pop-type operations read then decrement index.
// - Stack storage is not initialised on reset.
// - Stack storage only reachable through stack operations.
`timescale 1ns/1ps
`default_nettype none

module stack_and_pointer_addressing (
  input wire logic clock,
  input wire logic reset,
  // Data access request from the decoder.
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_byte,
  input wire logic acc_frame,
  input wire logic acc_dp_sel,
  input wire addr_stack_pkg::step_t acc_step,
  input wire logic [addr_stack_pkg::WORD_W-1:0] acc_wdata,
  // Direct pointer loads.
  input wire logic load_dp,
  input wire logic load_dp_sel,
  input wire logic load_base,
  input wire logic load_offset,
  input wire logic [addr_stack_pkg::WORD_W-1:0] load_value,
  // Stack requests.
  input wire addr_stack_pkg::stk_op_t stk_op,
  input wire logic [addr_stack_pkg::WORD_W-1:0] stk_wdata,
  input wire logic set_in_service,
  // Data memory side.
  input wire logic [addr_stack_pkg::WORD_W-1:0] mem_rdata,
  output logic mem_en,
  output logic mem_we,
  output logic mem_byte,
  output logic [addr_stack_pkg::WORD_W-1:0] mem_addr,
  output logic [addr_stack_pkg::WORD_W-1:0] mem_wdata,
  // Results to the decoder.
  output logic [addr_stack_pkg::WORD_W-1:0] rd_data,
  output logic rd_valid,
  output logic [addr_stack_pkg::WORD_W-1:0] stk_rdata,
  output logic stk_rvalid,
  output logic in_service_flag,
  output logic [addr_stack_pkg::WORD_W-1:0] data_pointer0,
  output logic [addr_stack_pkg::WORD_W-1:0] data_pointer1,
  output logic [addr_stack_pkg::WORD_W-1:0] frame_base,
  output logic [addr_stack_pkg::WORD_W-1:0] frame_offset,
  output logic [addr_stack_pkg::STACK_IDX_W-1:0] stack_index
);
  import addr_stack_pkg::*;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------

  // Stepped value of a pointer; wraps in 16 bits on purpose.
  function automatic logic [WORD_W-1:0] step_value(input logic [WORD_W-1:0] v,
                                                   input step_t s);
    case (s)
      STEP_INC: step_value = v + ONE;
      STEP_DEC: step_value = v - ONE;
      default: step_value = v;
    endcase
  endfunction : step_value

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [WORD_W-1:0] dp_q [NUM_DP];
  logic [WORD_W-1:0] dp_d [NUM_DP];
  logic [WORD_W-1:0] base_q;
  logic [WORD_W-1:0] offset_q;
  logic [WORD_W-1:0] offset_d;
  logic in_service_q;
  logic in_service_d;
  logic mem_en_q, mem_we_q, mem_byte_q;
  logic [WORD_W-1:0] mem_addr_q;
  logic [WORD_W-1:0] mem_wdata_q;
  logic rd_pending_q;
  logic rd_valid_q;
  logic [WORD_W-1:0] rd_data_q;
  logic [WORD_W-1:0] stk_rdata_q;
  logic stk_rvalid_q;

  // ---------------------------------------------------------------------------
  // Address formation
  // ---------------------------------------------------------------------------
  logic [WORD_W-1:0] dp_cur;
  logic [WORD_W-1:0] dp_stepped;
  logic [WORD_W-1:0] offset_stepped;
  logic [WORD_W-1:0] frame_cur;
  logic [WORD_W-1:0] frame_pre;
  logic [WORD_W-1:0] acc_addr;

  // Writes use the stepped pointer, reads the current one.
  assign dp_cur = dp_q[acc_dp_sel];
  assign dp_stepped = step_value(dp_cur, acc_step);
  assign offset_stepped = step_value(offset_q, acc_step);
  assign frame_cur = base_q + offset_q;
  assign frame_pre = base_q + offset_stepped;
  assign acc_addr = acc_frame ? (acc_write ? frame_pre : frame_cur)
                              : (acc_write ? dp_stepped : dp_cur);

  // ---------------------------------------------------------------------------
  // Pointer update
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DP; gi++) begin : g_dp
      // Either direct load or step of the selected pointer in this access.
      assign dp_d[gi] = (load_dp && load_dp_sel == 1'(gi)) ? load_value :
                        (acc_valid && !acc_frame && acc_dp_sel == 1'(gi)) ?
                        dp_stepped : dp_q[gi];
      always_ff @(posedge clock) begin
        if (reset) begin
          dp_q[gi] <= PTR_RESET;
        end else begin
          dp_q[gi] <= dp_d[gi];
        end
      end
    end
  endgenerate

  // Base never steps, so an offset carry cannot leak into it.
  assign offset_d = load_offset ? load_value :
                    (acc_valid && acc_frame) ? offset_stepped : offset_q;

  // Frame registers.
  always_ff @(posedge clock) begin
    if (reset) begin
      base_q <= PTR_RESET;
      offset_q <= PTR_RESET;
    end else begin
      base_q <= load_base ? load_value : base_q;
      offset_q <= offset_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Data memory cycle
  // ---------------------------------------------------------------------------

  // One request per clock; the strobe stands for exactly one cycle.
  always_ff @(posedge clock) begin
    if (reset) begin
      mem_en_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_byte_q <= 1'b0;
      mem_addr_q <= PTR_RESET;
      mem_wdata_q <= PTR_RESET;
      rd_pending_q <= 1'b0;
    end else begin
      mem_en_q <= acc_valid;
      mem_we_q <= acc_valid && acc_write;
      mem_byte_q <= acc_byte;
      mem_addr_q <= acc_addr;
      mem_wdata_q <= acc_byte ? {8'h00, acc_wdata[7:0]} : acc_wdata;
      rd_pending_q <= acc_valid && !acc_write;
    end
  end

  // Read data returns the cycle after the strobe; bytes come zero-extended.
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= PTR_RESET;
    end else begin
      rd_valid_q <= rd_pending_q;
      rd_data_q <= mem_byte_q ? {8'h00, mem_rdata[7:0]} : mem_rdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Hardware stack
  // ---------------------------------------------------------------------------
  logic stk_push;
  logic stk_pop;
  logic [WORD_W-1:0] stk_top;
  logic [STACK_IDX_W-1:0] stk_index;

  // Decode of stack operation class.
  assign stk_push = stk_op == STK_PUSH || stk_op == STK_CALL ||
                    stk_op == STK_VECTOR;
  assign stk_pop = stk_op[2];

  hw_stack u_stack (
    .clock(clock),
    .reset(reset),
    .push(stk_push),
    .pop(stk_pop),
    .push_data(stk_wdata),
    .top_data(stk_top),
    .stack_index(stk_index)
  );

  // Popped value is captured before the index falls.
  always_ff @(posedge clock) begin
    if (reset) begin
      stk_rvalid_q <= 1'b0;
      stk_rdata_q <= PTR_RESET;
    end else begin
      stk_rvalid_q <= stk_pop;
      stk_rdata_q <= stk_pop ? stk_top : stk_rdata_q;
    end
  end

  // In-service flag: vectoring sets it, so the set wins over a clear.
  assign in_service_d = (set_in_service || stk_op == STK_VECTOR) ? 1'b1 :
                        (stk_op == STK_POPC) ? 1'b0 : in_service_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      in_service_q <= 1'b0;
    end else begin
      in_service_q <= in_service_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign mem_en = mem_en_q;
  assign mem_we = mem_we_q;
  assign mem_byte = mem_byte_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign stk_rdata = stk_rdata_q;
  assign stk_rvalid = stk_rvalid_q;
  assign in_service_flag = in_service_q;
  assign data_pointer0 = dp_q[0];
  assign data_pointer1 = dp_q[1];
  assign frame_base = base_q;
  assign frame_offset = offset_q;
  assign stack_index = stk_index;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  dp_read_post_a: assert property (@(posedge clock) disable iff (reset)
    acc_valid && !acc_write && !acc_frame && !load_dp && acc_step == STEP_INC
    |=> mem_addr == $past(dp_cur) &&
        dp_q[$past(acc_dp_sel)] == $past(dp_cur) + ONE)
    else $error("read with increment did not use then step pointer");

  dp_write_pre_a: assert property (@(posedge clock) disable iff (reset)
    acc_valid && acc_write && !acc_frame && !load_dp && acc_step == STEP_DEC
    |=> mem_addr == $past(dp_cur) - ONE)
    else $error("write with decrement did not pre-step pointer");

  frame_sum_a: assert property (@(posedge clock) disable iff (reset)
    acc_valid && acc_frame && !acc_write
    |=> mem_addr == $past(base_q) + $past(offset_q))
    else $error("frame read address is not base plus offset");

  frame_pre_inc_a: assert property (@(posedge clock) disable iff (reset)
    acc_valid && acc_frame && acc_write && acc_step == STEP_INC && !load_offset
    |=> mem_addr == $past(base_q) + $past(offset_q) + ONE &&
        offset_q == $past(offset_q) + ONE)
    else $error("frame write increment misplaced");

  frame_post_dec_a: assert property (@(posedge clock) disable iff (reset)
    acc_valid && acc_frame && !acc_write && acc_step == STEP_DEC && !load_offset
    |=> offset_q == $past(offset_q) - ONE)
    else $error("frame read decrement missing");

  base_stable_a: assert property (@(posedge clock) disable iff (reset)
    !load_base |=> $stable(base_q))
    else $error("frame base changed without a load");

  one_cycle_a: assert property (@(posedge clock) disable iff (reset)
    acc_valid && !acc_write ##1 !acc_valid |-> mem_en ##1 !mem_en && rd_valid)
    else $error("memory cycle did not take one clock");

  popc_clear_a: assert property (@(posedge clock) disable iff (reset)
    stk_op == STK_POPC && !set_in_service
    |=> !in_service_flag && stk_rvalid && stack_index == $past(stack_index) - 4'h1)
    else $error("pop-and-clear misbehaved");

  reset_top_a: assert property (@(posedge clock)
    reset |=> stack_index == STACK_IDX_RESET)
    else $error("stack index not at top after reset");

endmodule : stack_and_pointer_addressing

`default_nettype wire

//--- tb/data_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------------
// Data memory on the far side of the block
// ---------------------------------------------------------------------------
module data_mem_model (
  input wire logic clock,
  input wire logic mem_en,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:255];
  logic [15:0] last_q;

  // Known fill so reads can be predicted; only the low address byte decodes.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'hC300 | 16'(i);
    end
    last_q = 16'h0000;
  end

  // Idle bus shows the inverse of the last word, so a stale value never matches.
  assign mem_rdata = mem_en ? mem[mem_addr[7:0]] : ~last_q;

  // A write lands at the end of its single access cycle.
  always @(posedge clock) begin
    if (mem_en) begin
      last_q <= mem[mem_addr[7:0]];
      if (mem_we && mem_byte) begin
        mem[mem_addr[7:0]][7:0] <= mem_wdata[7:0];
      end else if (mem_we) begin
        mem[mem_addr[7:0]] <= mem_wdata;
      end
    end
  end
endmodule : data_mem_model

`default_nettype wire

//--- tb/stack_and_pointer_addressing_test.sv
`timescale 1ns/1ps
`default_nettype none

module stack_and_pointer_addressing_test;
  import addr_stack_pkg::*;

  logic clock = 1'b0, reset = 1'b1;
  logic acc_valid = 1'b0, acc_write = 1'b0, acc_byte = 1'b0;
  logic acc_frame = 1'b0, acc_dp_sel = 1'b0, set_in_service = 1'b0;
  logic load_dp = 1'b0, load_dp_sel = 1'b0, load_base = 1'b0, load_offset = 1'b0;
  step_t acc_step = STEP_NONE;
  stk_op_t stk_op = STK_IDLE;
  logic [15:0] acc_wdata = 16'h0000, load_value = 16'h0000, stk_wdata = 16'h0000;
  logic [15:0] mem_rdata, mem_addr, mem_wdata, rd_data, stk_rdata;
  logic [15:0] data_pointer0, data_pointer1, frame_base, frame_offset;
  logic mem_en, mem_we, mem_byte, rd_valid, stk_rvalid, in_service_flag;
  logic [3:0] stack_index;
  int bad_count = 0;
  int cmp_count = 0;

  // Clock of 50 ns period.
  always #25 clock = ~clock;

  stack_and_pointer_addressing dut (
    .clock, .reset, .acc_valid, .acc_write, .acc_byte, .acc_frame, .acc_dp_sel,
    .acc_step, .acc_wdata, .load_dp, .load_dp_sel, .load_base, .load_offset,
    .load_value, .stk_op, .stk_wdata, .set_in_service, .mem_rdata, .mem_en,
    .mem_we, .mem_byte, .mem_addr, .mem_wdata, .rd_data, .rd_valid, .stk_rdata,
    .stk_rvalid, .in_service_flag, .data_pointer0, .data_pointer1, .frame_base,
    .frame_offset, .stack_index
  );

  data_mem_model mem_i (
    .clock, .mem_en, .mem_we, .mem_byte, .mem_addr, .mem_wdata, .mem_rdata
  );

  // ---------------------------------------------------------------------------
  // Compare and bus tasks
  // ---------------------------------------------------------------------------
  task automatic chk_word(input logic [15:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, exp, input string m);
    chk_word({15'h0000, got}, {15'h0000, exp}, m);
  endtask : chk_bit

  task automatic chk_idx(input logic [3:0] got, exp, input string m);
    chk_word({12'h000, got}, {12'h000, exp}, m);
  endtask : chk_idx

  function automatic logic [15:0] pat(input logic [15:0] a);
    return 16'hC300 | {8'h00, a[7:0]};
  endfunction : pat

  // Loads: 0 and 1 data pointers, 2 frame base, 3 frame offset.
  task automatic load(input int k, input logic [15:0] v);
    @(posedge clock);
    load_value <= v;
    load_dp <= (k < 2);
    load_dp_sel <= (k == 1);
    load_base <= (k == 2);
    load_offset <= (k == 3);
    @(posedge clock);
    load_dp <= 1'b0;
    load_base <= 1'b0;
    load_offset <= 1'b0;
  endtask : load

  // One data access, checked in the strobe cycle and in the result cycle.
  task automatic acc(input logic w, b, f, sel, input step_t s,
                     input logic [15:0] wd, ea, er);
    @(posedge clock);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_byte <= b;
    acc_frame <= f;
    acc_dp_sel <= sel;
    acc_step <= s;
    acc_wdata <= wd;
    @(posedge clock);
    acc_valid <= 1'b0;
    #1;
    chk_bit(mem_en, 1'b1, "mem_en");
    chk_bit(mem_we, w, "mem_we");
    chk_bit(mem_byte, b, "mem_byte");
    chk_word(mem_addr, ea, "mem_addr");
    if (w) chk_word(mem_wdata, b ? {8'h00, wd[7:0]} : wd, "mem_wdata");
    @(posedge clock);
    #1;
    chk_bit(mem_en, 1'b0, "mem_en held");
    chk_bit(rd_valid, !w, "rd_valid");
    if (!w) chk_word(rd_data, er, "rd_data");
  endtask : acc

  // One stack request followed by an idle cycle.
  task automatic stk(input stk_op_t op, input logic [15:0] d, e);
    @(posedge clock);
    stk_op <= op;
    stk_wdata <= d;
    @(posedge clock);
    stk_op <= STK_IDLE;
    #1;
    chk_bit(mem_en, 1'b0, "stack used data memory");
    chk_bit(stk_rvalid, op[2], "stk_rvalid");
    if (op[2]) chk_word(stk_rdata, e, "stk_rdata");
  endtask : stk

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    chk_idx(stack_index, 4'hF, "reset index");
    chk_word(data_pointer0, 16'h0000, "reset pointer");
    chk_bit(in_service_flag, 1'b0, "reset flag");
    $display("test reset done");
  endtask : t_reset

  // Reads step after the transfer, writes step before it.
  task automatic t_dp;
    step_t s;
    logic [15:0] n;
    for (int i = 0; i < 2; i++) begin
      s = i ? STEP_DEC : STEP_INC;
      n = i ? 16'h003F : 16'h0041;
      load(0, 16'h0040);
      acc(0, 0, 0, 0, s, 16'h0000, 16'h0040, pat(16'h0040));
      chk_word(data_pointer0, n, "post step");
      load(1, 16'h0040);
      acc(1, 0, 0, 1, s, 16'h5A00 + n, n, 16'h0000);
      chk_word(data_pointer1, n, "pre step");
      load(0, n);
      acc(0, 0, 0, 0, STEP_NONE, 16'h0000, n, 16'h5A00 + n);
    end
    $display("test data pointer done");
  endtask : t_dp

  // Offset wraps both ways while the base stays put.
  task automatic t_frame;
    load(2, 16'hFFF0);
    load(3, 16'h000F);
    acc(0, 0, 1, 0, STEP_INC, 16'h0000, 16'hFFFF, pat(16'hFFFF));
    chk_word(frame_offset, 16'h0010, "offset");
    load(3, 16'h0000);
    acc(1, 0, 1, 0, STEP_DEC, 16'h7E7E, 16'hFFEF, 16'h0000);
    chk_word(frame_offset, 16'hFFFF, "offset");
    chk_word(frame_base, 16'hFFF0, "base");
    acc(1, 0, 1, 0, STEP_INC, 16'h1111, 16'hFFF0, 16'h0000);
    chk_word(frame_base, 16'hFFF0, "base");
    acc(0, 0, 1, 0, STEP_DEC, 16'h0000, 16'hFFF0, 16'h1111);
    chk_word(frame_offset, 16'hFFFF, "offset");
    chk_word(frame_base, 16'hFFF0, "base");
    $display("test frame done");
  endtask : t_frame

  task automatic t_byte;
    load(0, 16'h0080);
    acc(1, 1, 0, 0, STEP_NONE, 16'hABCD, 16'h0080, 16'h0000);
    acc(0, 1, 0, 0, STEP_NONE, 16'h0000, 16'h0080, 16'h00CD);
    acc(0, 0, 0, 0, STEP_NONE, 16'h0000, 16'h0080, 16'hC3CD);
    $display("test byte done");
  endtask : t_byte

  // Full lap of all sixteen entries with every operation kind except pop-and-clear.
  task automatic t_stack;
    stk_op_t op;
    for (int i = 0; i < 16; i++) begin
      op = (i % 3 == 0) ? STK_PUSH : (i % 3 == 1) ? STK_CALL : STK_VECTOR;
      stk(op, 16'hF000 + 16'(i), 16'h0000);
      chk_idx(stack_index, 4'(i), "index up");
    end
    chk_bit(in_service_flag, 1'b1, "vector flag");
    for (int i = 15; i >= 0; i--) begin
      op = (i % 3 == 0) ? STK_POP : (i % 3 == 1) ? STK_RET : stk_op_t'(3'b110);
      stk(op, 16'h0000, 16'hF000 + 16'(i));
      chk_idx(stack_index, 4'(i + 15), "index down");
    end
    @(posedge clock);
    stk_op <= STK_PUSH;
    stk_wdata <= 16'hBEEF;
    @(posedge clock);
    stk_op <= STK_POP;
    @(posedge clock);
    stk_op <= STK_IDLE;
    #1;
    chk_bit(stk_rvalid, 1'b1, "back to back");
    chk_word(stk_rdata, 16'hBEEF, "back to back");
    $display("test stack done");
  endtask : t_stack

  task automatic t_service;
    stk(STK_PUSH, 16'h0001, 16'h0000);
    stk(STK_POPC, 16'h0000, 16'h0001);
    chk_bit(in_service_flag, 1'b0, "flag cleared");
    chk_idx(stack_index, 4'hF, "index");
    stk(STK_PUSH, 16'h0002, 16'h0000);
    @(posedge clock);
    set_in_service <= 1'b1;
    stk_op <= STK_POPC;
    @(posedge clock);
    set_in_service <= 1'b0;
    stk_op <= STK_IDLE;
    #1;
    chk_word(stk_rdata, 16'h0002, "pop and clear");
    chk_bit(in_service_flag, 1'b1, "set wins");
    $display("test service done");
  endtask : t_service

  // Reset in mid-run must bring data pointer 1, the frame base and offset and the stack index back.
  task automatic t_mid_reset;
    stk(STK_VECTOR, 16'h1234, 16'h0000);
    load(1, 16'h0055);
    load(2, 16'h0101);
    load(3, 16'h0202);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk_idx(stack_index, STACK_IDX_RESET, "mid reset index");
    chk_word(data_pointer1, 16'h0000, "mid reset pointer");
    chk_word(frame_base, 16'h0000, "mid reset base");
    chk_word(frame_offset, 16'h0000, "mid reset offset");
    chk_bit(in_service_flag, 1'b0, "mid reset flag");
    chk_bit(mem_en, 1'b0, "mid reset strobe");
    chk_bit(rd_valid, 1'b0, "mid reset read valid");
    chk_bit(stk_rvalid, 1'b0, "mid reset pop valid");
    $display("test mid reset done");
  endtask : t_mid_reset

  // Main sequence.
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    #1;
    t_reset();
    t_dp();
    t_frame();
    t_byte();
    t_stack();
    t_service();
    t_mid_reset();
    finish_test();
  end

  // Watchdog well beyond the roughly 155 cycles the scenarios need.
  initial begin
    repeat (4000) @(posedge clock);
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule : stack_and_pointer_addressing_test

`default_nettype wire
